// *** logic/power_down_wake_control.sv ***
`timescale 1ns/1ps
// Contract
// - executing the power-down instruction enters power-down.
// - on entry an enabled watchdog is cleared and keeps counting.
// - on entry power-down flag clears, time-out flag sets.
// - on entry the oscillator driver turns off.
// - ports keep their pre-sleep drive state while asleep.
// - wake on master-clear, watchdog time-out or a wake interrupt.
// - watchdog wakes only when enabled.
// - master-clear resets fully; other wakes resume execution.
// - power-down flag is set at power-up.
// - watchdog wake clears the time-out flag.
// - peripheral wake sources are timer one, capture and special event.
// - timer one wakes only in asynchronous external counting; the logic needs only the asynchronous bit, not the external one.
// - special event wakes only with asynchronous external timer one.
// - other peripherals raise no interrupt while asleep.
// - interrupt flags set regardless of enable bits.
// - servicing clears global enable, pushes return, vectors to 0004h.
module power_down_wake_control
  import pwr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sleep_exec,
  input wire logic master_clear_n,
  input wire logic wdt_timeout,
  input wire logic [NSRC-1:0] irq_cond,
  input wire logic [12:0] pc_next,
  input wire logic retfie_exec,
  input wire logic [7:0] port_out_in,
  input wire logic [7:0] port_oe_in,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic wdt_clear,
  output logic osc_en,
  output logic core_halt,
  output logic device_reset,
  output logic [7:0] port_out,
  output logic [7:0] port_oe,
  output logic vector_load,
  output logic [12:0] vector_pc,
  output logic [12:0] push_addr,
  output logic push_en,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    pwr_state_t st;
    logic [7:0] status;
    logic [7:0] ctrl;
    logic [NSRC-1:0] ien;
    logic [NSRC-1:0] iflag;
    logic [NEV-1:0] evs;
    logic [NEV-1:0] evm;
    logic [7:0] rdata;
    logic wdt_clear;
    logic osc_en;
    logic core_halt;
    logic device_reset;
    logic [7:0] port_out;
    logic [7:0] port_oe;
    logic vector_load;
    logic [12:0] vector_pc;
    logic [12:0] push_addr;
    logic push_en;
    logic irq;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic irq_wake;
  logic wdt_wake;
  logic [NSRC-1:0] cond_live;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pad_src(input logic [NSRC-1:0] v);
    pad_src = {{(8-NSRC){1'b0}}, v};
  endfunction

  function automatic logic [7:0] pad_ev(input logic [NEV-1:0] v);
    pad_ev = {{(8-NEV){1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  wake_sel u_wake_sel (
    .flags(s_q.iflag),
    .enables(s_q.ien),
    .t1_async(s_q.ctrl[CTRL_T1_ASYNC]),
    .t1_ext(s_q.ctrl[CTRL_T1_EXT]),
    .wdt_en(s_q.ctrl[CTRL_WDT_EN]),
    .wdt_timeout(wdt_timeout),
    .irq_wake(irq_wake),
    .wdt_wake(wdt_wake)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.wdt_clear = 1'b0;
    s_d.device_reset = 1'b0;
    s_d.vector_load = 1'b0;
    s_d.push_en = 1'b0;
    cond_live = irq_cond;
    // only the other-peripheral source is kept from flagging while asleep
    if (s_q.st == ST_SLEEP)
    begin
      cond_live[SRC_OTHER] = 1'b0;
    end

    // register writes; a hardware set below wins over a clear here
    if (wr_en)
    begin
      unique case (addr)
        A_STATUS: s_d.status = wdata;
        A_CTRL: s_d.ctrl = wdata;
        A_IRQ_EN: s_d.ien = wdata[NSRC-1:0];
        A_IRQ_FLAG: s_d.iflag = s_q.iflag & ~wdata[NSRC-1:0];
        A_EVT_STAT: s_d.evs = s_q.evs & ~wdata[NEV-1:0];
        A_EVT_MASK: s_d.evm = wdata[NEV-1:0];
        default: ;
      endcase
    end
    if (rd_en)
    begin
      unique case (addr)
        A_STATUS: s_d.rdata = s_q.status;
        A_CTRL: s_d.rdata = s_q.ctrl;
        A_IRQ_EN: s_d.rdata = pad_src(s_q.ien);
        A_IRQ_FLAG: s_d.rdata = pad_src(s_q.iflag);
        A_EVT_STAT: s_d.rdata = pad_ev(s_q.evs);
        A_EVT_MASK: s_d.rdata = pad_ev(s_q.evm);
        A_STATE: s_d.rdata = {5'h00, s_q.st};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // flags set independent of any enable
    s_d.iflag = s_d.iflag | cond_live;

    unique case (s_q.st)
      ST_RUN:
      begin
        s_d.port_out = port_out_in;
        s_d.port_oe = port_oe_in;
        if (sleep_exec)
        begin
          s_d.st = ST_SLEEP;
          s_d.wdt_clear = s_q.ctrl[CTRL_WDT_EN];
          s_d.status[PD_BIT] = 1'b0;
          s_d.status[TO_BIT] = 1'b1;
          s_d.osc_en = 1'b0;
          s_d.core_halt = 1'b1;
          s_d.evs[EV_SLEEP] = 1'b1;
        end
        else if (s_q.ctrl[CTRL_GIE] && ((s_q.iflag & s_q.ien) != '0))
        begin
          s_d.ctrl[CTRL_GIE] = 1'b0;
          s_d.push_en = 1'b1;
          s_d.push_addr = pc_next;
          s_d.vector_load = 1'b1;
          s_d.vector_pc = IRQ_VECTOR;
        end
        else if (retfie_exec)
        begin
          s_d.ctrl[CTRL_GIE] = 1'b1;
        end
      end
      ST_SLEEP:
      begin
        // port outputs frozen at entry values
        if (wdt_wake)
        begin
          s_d.st = ST_WAKE;
          s_d.status[TO_BIT] = 1'b0;
          s_d.evs[EV_WDT] = 1'b1;
        end
        else if (irq_wake)
        begin
          s_d.st = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        // oscillator back, core resumes where it stopped
        s_d.osc_en = 1'b1;
        s_d.core_halt = 1'b0;
        s_d.st = ST_RUN;
        s_d.evs[EV_WAKE] = 1'b1;
      end
      default: s_d.st = ST_RUN;
    endcase

    // master-clear during sleep is a full reset, not a resume
    // relies on the pin being held high while asleep
    if (!master_clear_n)
    begin
      s_d.st = ST_RUN;
      s_d.device_reset = 1'b1;
      s_d.osc_en = 1'b1;
      s_d.core_halt = 1'b0;
      // full reset restores control; status keeps the wake cause for software
      s_d.ctrl = CTRL_RST;
      s_d.port_oe = 8'h00;
      if (s_q.st == ST_SLEEP)
      begin
        s_d.evs[EV_MASTER_CLEAR_N] = 1'b1;
      end
    end

    s_d.irq = (s_d.evs & s_d.evm) != '0;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.st <= ST_RUN;
      s_q.status <= STATUS_RST; // power-up sets pd
      s_q.ctrl <= CTRL_RST;
      s_q.osc_en <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign wdt_clear = s_q.wdt_clear;
  assign osc_en = s_q.osc_en;
  assign core_halt = s_q.core_halt;
  assign device_reset = s_q.device_reset;
  assign port_out = s_q.port_out;
  assign port_oe = s_q.port_oe;
  assign vector_load = s_q.vector_load;
  assign vector_pc = s_q.vector_pc;
  assign push_addr = s_q.push_addr;
  assign push_en = s_q.push_en;
  assign irq = s_q.irq;

endmodule

// *** logic/pwr_pkg.sv ***
package pwr_pkg;
  // status bit positions
  localparam int unsigned PD_BIT = 3;
  localparam int unsigned TO_BIT = 4;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // interrupt vector
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  // register map of the plain port
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_CTRL = 4'h1;
  localparam logic [3:0] A_IRQ_EN = 4'h2;
  localparam logic [3:0] A_IRQ_FLAG = 4'h3;
  localparam logic [3:0] A_EVT_STAT = 4'h4;
  localparam logic [3:0] A_EVT_MASK = 4'h5;
  localparam logic [3:0] A_STATE = 4'h6;
  // interrupt source positions
  localparam int unsigned SRC_EXT = 0;
  localparam int unsigned SRC_PORTB = 1;
  localparam int unsigned SRC_T1 = 2;
  localparam int unsigned SRC_CAP = 3;
  localparam int unsigned SRC_SPEC = 4;
  localparam int unsigned SRC_OTHER = 5;
  localparam int unsigned NSRC = 6;
  // ctrl bits
  localparam int unsigned CTRL_GIE = 0;
  localparam int unsigned CTRL_WDT_EN = 1;
  localparam int unsigned CTRL_T1_ASYNC = 2;
  localparam int unsigned CTRL_T1_EXT = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // event status bits
  localparam int unsigned EV_SLEEP = 0;
  localparam int unsigned EV_WAKE = 1;
  localparam int unsigned EV_WDT = 2;
  localparam int unsigned EV_MASTER_CLEAR_N = 3;
  localparam int unsigned NEV = 4;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } pwr_state_t;
endpackage

// *** logic/wake_sel.sv ***
`timescale 1ns/1ps
module wake_sel
  import pwr_pkg::*;
(
  input wire logic [NSRC-1:0] flags,
  input wire logic [NSRC-1:0] enables,
  input wire logic t1_async,
  input wire logic t1_ext,
  input wire logic wdt_en,
  input wire logic wdt_timeout,
  output logic irq_wake,
  output logic wdt_wake
);
  logic [NSRC-1:0] able;
  always_comb
  begin
    able = '0;
    able[SRC_EXT] = 1'b1;
    able[SRC_PORTB] = 1'b1;
    able[SRC_T1] = t1_async;
    able[SRC_CAP] = 1'b1;
    able[SRC_SPEC] = t1_async & t1_ext;
    able[SRC_OTHER] = 1'b0; // no clock for it while asleep
    irq_wake = |(flags & enables & able);
    wdt_wake = wdt_en & wdt_timeout;
  end
endmodule

// *** dv/pwr_monitor.sv ***
`timescale 1ns/1ps
module pwr_monitor
  import pwr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sleep_exec,
  input wire logic master_clear_n,
  input wire logic wdt_timeout,
  input wire logic [NSRC-1:0] irq_cond,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic wdt_clear,
  input wire logic osc_en,
  input wire logic core_halt,
  input wire logic device_reset,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  input wire logic vector_load,
  input wire logic [12:0] vector_pc,
  input wire logic push_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_sleep_halts: assert property (
    sleep_exec && !core_halt && master_clear_n |=> core_halt)
    else $error("no halt after sleep");
  a_osc_off_halt: assert property (osc_en != core_halt)
    else $error("oscillator state wrong");
  a_wdt_cause: assert property (wdt_clear |-> $past(sleep_exec))
    else $error("watchdog clear without sleep");
  a_ports_frozen: assert property (
    core_halt && $past(core_halt) && master_clear_n && $past(master_clear_n)
    |-> $stable(port_out) && $stable(port_oe))
    else $error("ports moved while asleep");
  a_master_clear_n_reset: assert property (!master_clear_n |=> device_reset)
    else $error("no reset on master clear");
  a_reset_cause: assert property (device_reset |-> !$past(master_clear_n))
    else $error("reset without master clear");
  // inputs quiet for four cycles covers the three-edge wake pipeline
  a_quiet_sleep: assert property (
    (core_halt && master_clear_n && !wdt_timeout && irq_cond == 6'h00) [*4]
    |=> core_halt)
    else $error("woke without cause");
  a_vector_pc: assert property (
    vector_load |-> vector_pc == IRQ_VECTOR && push_en)
    else $error("bad vector");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read");
  cover property (vector_load);
  cover property ($fell(core_halt));
  cover property (device_reset);
endmodule
bind power_down_wake_control pwr_monitor mon (.sys_clk, .nrst, .sleep_exec,
  .master_clear_n, .wdt_timeout, .irq_cond, .rd_en, .rdata, .wdt_clear,
  .osc_en, .core_halt, .device_reset, .port_out, .port_oe, .vector_load,
  .vector_pc, .push_en);

// *** dv/core_model.sv ***
`timescale 1ns/1ps
module core_model
(
  input wire logic sys_clk,
  output logic [7:0] port_out_in,
  output logic [7:0] port_oe_in,
  output logic [12:0] pc_next
);
  logic [12:0] cnt_q = 13'h0000;
  // live output drive moves every cycle, enable drive every 32 cycles, so a leak past the freeze shows
  always_ff @(posedge sys_clk)
    cnt_q <= cnt_q + 13'h0001;
  assign port_out_in = cnt_q[7:0];
  assign port_oe_in = ~cnt_q[12:5];
  assign pc_next = cnt_q;
endmodule

// *** dv/power_down_wake_control_tb_top.sv ***
`timescale 1ns/1ps
module power_down_wake_control_tb_top
  import pwr_pkg::*;
;
  logic sys_clk = 0, nrst = 0, sleep_exec = 0, wdt_timeout = 0;
  logic master_clear_n = 1;
  logic retfie_exec = 0, wr_en = 0, rd_en = 0;
  logic [NSRC-1:0] irq_cond = 6'h00;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, port_out, port_oe, pout, poe;
  logic [12:0] pc_next, vector_pc, push_addr;
  logic wdt_clear, osc_en, core_halt, device_reset, vector_load, push_en, irq;
  logic [15:0] po;
  int error_cnt = 0, comparisons = 0;
  core_model cm (.sys_clk, .port_out_in(pout), .port_oe_in(poe), .pc_next);
  power_down_wake_control uut (.sys_clk, .nrst, .sleep_exec, .master_clear_n,
    .wdt_timeout, .irq_cond, .pc_next, .retfie_exec, .port_out_in(pout),
    .port_oe_in(poe), .addr, .wdata, .wr_en, .rd_en, .rdata, .wdt_clear,
    .osc_en, .core_halt, .device_reset, .port_out, .port_oe, .vector_load,
    .vector_pc, .push_addr, .push_en, .irq);
  initial
    forever #12.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(16'(rdata), 16'(e));
  endtask
  task drive(input logic [5:0] c, input logic w);
    @(posedge sys_clk);
    irq_cond <= c;
    wdt_timeout <= w;
    @(posedge sys_clk);
    irq_cond <= 6'h00;
    wdt_timeout <= 1'b0;
  endtask
  task sleep_now;
    @(posedge sys_clk);
    sleep_exec <= 1'b1;
    @(posedge sys_clk);
    sleep_exec <= 1'b0;
    #1;
  endtask
  task stays;
    repeat (6) @(posedge sys_clk);
    #1;
    chk(16'(core_halt), 16'h0001);
  endtask
  // s picks the awaited event: 0 vectoring, 1 wake
  task wait_hi(input logic s);
    int i;
    for (i = 0; i < 10; i++)
    begin
      #1;
      if ((s ? !core_halt : vector_load) === 1'b1)
        break;
      @(posedge sys_clk);
    end
    chk(16'(i < 10), 16'h0001);
    if (i == 10)
      print_verdict;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(A_STATUS, STATUS_RST);
    rd(A_CTRL, CTRL_RST);
    rd(4'hF, 8'h00);
  endtask
  task t_vector;
    wr(A_IRQ_EN, 8'h01);
    wr(A_CTRL, 8'h01);
    drive(6'h01, 1'b0);
    wait_hi(1'b0);
    chk(16'({vector_pc, push_en}), 16'(IRQ_VECTOR) << 1 | 16'h0001);
    // the model's counter has stepped once since the design sampled it
    chk(16'(push_addr), 16'(pc_next - 13'h0001));
    rd(A_CTRL, 8'h00);
    wr(A_IRQ_FLAG, 8'h3F);
    @(posedge sys_clk);
    retfie_exec <= 1'b1;
    @(posedge sys_clk);
    retfie_exec <= 1'b0;
    rd(A_CTRL, 8'h01);
    wr(A_CTRL, 8'h00);
  endtask
  task t_irq_wake;
    wr(A_IRQ_EN, 8'h3D);
    wr(A_EVT_STAT, 8'h0F);
    wr(A_EVT_MASK, 8'h01);
    sleep_now;
    chk(16'({osc_en, core_halt, wdt_clear}), 16'h0002);
    po = {port_oe, port_out};
    rd(A_STATUS, 8'h10);
    chk(16'(irq), 16'h0001);
    drive(6'h20, 1'b0);
    drive(6'h04, 1'b0);
    drive(6'h02, 1'b0);
    stays;
    chk({port_oe, port_out}, po);
    rd(A_IRQ_FLAG, 8'h06);
    wr(A_IRQ_FLAG, 8'h26);
    drive(6'h01, 1'b0);
    wait_hi(1'b1);
    rd(A_STATUS, 8'h10);
    wr(A_EVT_STAT, 8'h0F);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(16'(irq), 16'h0000);
    wr(A_IRQ_FLAG, 8'h3F);
  endtask
  task t_periph_wake;
    wr(A_IRQ_FLAG, 8'h3F);
    wr(A_CTRL, 8'h04);
    sleep_now;
    drive(6'h10, 1'b0);
    stays;
    drive(6'h04, 1'b0);
    wait_hi(1'b1);
    wr(A_IRQ_FLAG, 8'h3F);
    wr(A_CTRL, 8'h0C);
    sleep_now;
    drive(6'h10, 1'b0);
    wait_hi(1'b1);
    wr(A_IRQ_FLAG, 8'h3F);
    sleep_now;
    drive(6'h08, 1'b0);
    wait_hi(1'b1);
    wr(A_IRQ_FLAG, 8'h3F);
    wr(A_CTRL, 8'h00);
  endtask
  task t_wdt;
    sleep_now;
    drive(6'h00, 1'b1);
    stays;
    wr(A_CTRL, 8'h02);
    drive(6'h00, 1'b1);
    wait_hi(1'b1);
    rd(A_STATUS, 8'h00);
  endtask
  task t_master_clear_n;
    sleep_now;
    chk(16'({osc_en, core_halt, wdt_clear}), 16'h0003);
    @(posedge sys_clk);
    master_clear_n <= 1'b0;
    @(posedge sys_clk);
    master_clear_n <= 1'b1;
    #1;
    chk(16'(device_reset), 16'h0001);
    wait_hi(1'b1);
    rd(A_CTRL, CTRL_RST);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_vector;
    t_irq_wake;
    t_periph_wake;
    t_wdt;
    t_master_clear_n;
    print_verdict;
  end
endmodule
